/* rtl/msc_pkg.sv */
package msc_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] ADDR_HOLD    = 8'h00;
  localparam logic [7:0] ADDR_MINRATE = 8'h04;
  localparam logic [7:0] ADDR_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_CONFIG  = 8'h0C;
  localparam logic [7:0] ADDR_CMD     = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_SNAPV   = 8'h18;
  localparam logic [7:0] ADDR_SNAPIO  = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int CFG_SIGERR = 0;
  localparam int CFG_EDGE   = 1;
  localparam int CFG_CONT   = 2;
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_TEST   = 2;
  localparam int CMD_TCONT  = 3;
  localparam int CMD_ESC    = 4;
  localparam int ST_CRIT    = 0;
  localparam int ST_CALAB   = 1;
  localparam int ST_OTEMP   = 2;
  localparam int ST_HOLDX   = 3;
  localparam int ST_RLOW    = 4;
  localparam int ST_RED     = 5;
  localparam int ST_STOUT   = 6;
  localparam int ST_LRUN    = 7;
  localparam int ST_TEST    = 8;
  localparam int ST_PORT    = 9;

  // ==========================================================
  // Limits and reset values
  localparam logic [15:0] HOLD_MIN     = 16'h000A;
  localparam logic [15:0] HOLD_RESET   = 16'h0064;
  localparam logic [6:0]  MINRATE_MAX  = 7'h63;
  localparam logic [6:0]  MINRATE_RST  = 7'h00;
  localparam logic [7:0]  TEMP_LIMIT_C = 8'h4B;
  localparam logic [1:0]  PORT_ONE_ID  = 2'h1;
  localparam logic [1:0]  PORT_TWO_ID  = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int MS_NS           = 1000000;
  localparam int TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int REFRESH_MS      = 250;
  localparam int TEST_TIMEOUT_S  = 60;
  localparam int TEST_TIMEOUT_MS = TEST_TIMEOUT_S * 1000;

  // ==========================================================
  // Characters seen by the line filter, and the escape that ends a test display
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_ESC  = 8'h1B;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_DASH = 8'h2D;
  localparam logic [7:0] CH_GT   = 8'h3E;
  localparam logic [7:0] CH_S    = 8'h53;
  localparam logic [7:0] CH_SL   = 8'h2F;
  localparam logic [7:0] CH_N    = 8'h4E;
  localparam logic [7:0] CH_R    = 8'h52;
  localparam logic [7:0] CH_E    = 8'h45;
  localparam logic [7:0] CH_M    = 8'h4D;

  // Measurement values captured by the test display
  typedef struct packed {
    logic [15:0] velocity;
    logic [6:0]  rate;
    logic [2:0]  din;
    logic [7:0]  lighting;
  } msc_meas_t;

endpackage

/* rtl/msc_supervisor.sv */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
module msc_supervisor #(
  parameter int TICK_CYC = msc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Measurement side
  input  wire logic        signal_valid,
  input  wire logic [15:0] velocity_in,
  input  wire logic [6:0]  rate_in,
  input  wire logic        avg_end,
  input  wire logic        standstill,
  input  wire logic        no_material,
  input  wire logic        trigger_event,
  input  wire logic        calibrating,
  input  wire logic [7:0]  temp_c,
  input  wire logic        digital_input_zero,
  input  wire logic        digital_input_one,
  input  wire logic        digital_input_two,
  input  wire logic [7:0]  lighting,
  // Command characters from the serial ports
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_char,
  input  wire logic        cmd_from_port_two,
  // Filtered command characters
  output logic             line_valid,
  output logic [7:0]       line_char,
  output logic             line_drop,
  // Supervision outputs
  output logic [15:0]      velocity_out,
  output logic             red_led,
  output logic             status_output,
  output logic             length_run,
  output logic             length_clear,
  output logic             critical_error,
  output logic             cal_abort,
  output logic             over_temperature_error,
  output logic             test_refresh,
  output logic             data_output_block
);

  // ==========================================================
  // Elaboration check, a zero tick length would never produce a millisecond
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be at least one");
  end

  // ==========================================================
  // APB decode, no wait states
  logic wr_en;
  logic rd_setup;
  logic mapped;
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable;
  always_comb begin
    unique case (paddr)
      msc_pkg::ADDR_HOLD, msc_pkg::ADDR_MINRATE, msc_pkg::ADDR_COUNT,
      msc_pkg::ADDR_CONFIG, msc_pkg::ADDR_CMD, msc_pkg::ADDR_STATUS,
      msc_pkg::ADDR_SNAPV, msc_pkg::ADDR_SNAPIO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  logic wr_hold, wr_minrate, wr_count, wr_cfg, wr_cmd, wr_status;
  assign wr_hold    = wr_en && paddr == msc_pkg::ADDR_HOLD;
  assign wr_minrate = wr_en && paddr == msc_pkg::ADDR_MINRATE;
  assign wr_count   = wr_en && paddr == msc_pkg::ADDR_COUNT;
  assign wr_cfg     = wr_en && paddr == msc_pkg::ADDR_CONFIG;
  assign wr_cmd     = wr_en && paddr == msc_pkg::ADDR_CMD;
  assign wr_status  = wr_en && paddr == msc_pkg::ADDR_STATUS;

  // ==========================================================
  // Settings
  logic [15:0] hold_q;
  logic [6:0]  minrate_q;
  logic [2:0]  cfg_q;
  // Out-of-range values are dropped so the stored setting stays legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q    <= msc_pkg::HOLD_RESET;
      minrate_q <= msc_pkg::MINRATE_RST;
      cfg_q     <= 3'h0;
    end else begin
      if (wr_hold && pwdata[31:16] == 16'h0000 && pwdata[15:0] >= msc_pkg::HOLD_MIN) begin
        hold_q <= pwdata[15:0];
      end
      if (wr_minrate && pwdata[31:7] == 25'h0 && pwdata[6:0] <= msc_pkg::MINRATE_MAX) begin
        minrate_q <= pwdata[6:0];
      end
      if (wr_cfg) begin
        cfg_q <= pwdata[2:0];
      end
    end
  end

  logic sigerr_en, edge_en, cont_mode;
  assign sigerr_en = cfg_q[msc_pkg::CFG_SIGERR];
  assign edge_en   = cfg_q[msc_pkg::CFG_EDGE];
  assign cont_mode = cfg_q[msc_pkg::CFG_CONT];

  // ==========================================================
  // Millisecond tick, free running
  logic [31:0] tick_cnt_q;
  logic        ms_tick;
  assign ms_tick = tick_cnt_q == 32'(TICK_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= ms_tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // Hold timer and velocity output
  logic [15:0] hold_cnt_q;
  logic        expired_q;
  logic        expire_now;
  assign expire_now = ~signal_valid & ~expired_q & ms_tick & (hold_cnt_q + 16'h1 >= hold_q);
  // First tick may come early, so a hold is exact to within one millisecond
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q   <= 16'h0;
      expired_q    <= 1'b0;
      velocity_out <= 16'h0;
    end else if (signal_valid) begin
      hold_cnt_q   <= 16'h0;
      expired_q    <= 1'b0;
      velocity_out <= velocity_in;
    end else if (expire_now) begin
      expired_q    <= 1'b1;
      velocity_out <= 16'h0;
    end else if (ms_tick && !expired_q) begin
      hold_cnt_q <= hold_cnt_q + 16'h1;
    end
  end

  // ==========================================================
  // Rate monitoring
  logic rate_low_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_low_q <= 1'b0;
    end else if (edge_en || minrate_q == 7'h00) begin
      rate_low_q <= 1'b0;
    end else if (avg_end) begin
      rate_low_q <= rate_in < minrate_q;
    end
  end

  // Indicator and status output
  assign status_output = rate_low_q | standstill | no_material;
  assign red_led       = status_output | expired_q;

  // ==========================================================
  // Parts counter, load beats a same-cycle trigger
  logic [15:0] count_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0;
    end else if (wr_count) begin
      count_q <= pwdata[15:0];
    end else if (trigger_event) begin
      count_q <= count_q + 16'h1;
    end
  end

  // ==========================================================
  // Length integration control
  logic cmd_start, cmd_stop;
  assign cmd_start = wr_cmd & pwdata[msc_pkg::CMD_START];
  assign cmd_stop  = wr_cmd & pwdata[msc_pkg::CMD_STOP];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      length_run   <= 1'b0;
      length_clear <= 1'b0;
    end else begin
      length_clear <= cmd_start;
      if (cmd_start) begin
        length_run <= 1'b1;
      end else if (cmd_stop && !cont_mode) begin
        length_run <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sticky errors, set wins over a clearing write
  logic crit_set, calab_set, otemp_set;
  logic calab_q;
  assign crit_set  = expire_now & sigerr_en & length_run;
  assign calab_set = expire_now & sigerr_en & calibrating;
  assign otemp_set = $signed(temp_c) > $signed(msc_pkg::TEMP_LIMIT_C);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      critical_error         <= 1'b0;
      calab_q                <= 1'b0;
      over_temperature_error <= 1'b0;
      cal_abort              <= 1'b0;
    end else begin
      cal_abort <= calab_set;
      if (crit_set) begin
        critical_error <= 1'b1;
      end else if (wr_status && pwdata[msc_pkg::ST_CRIT]) begin
        critical_error <= 1'b0;
      end
      if (calab_set) begin
        calab_q <= 1'b1;
      end else if (wr_status && pwdata[msc_pkg::ST_CALAB]) begin
        calab_q <= 1'b0;
      end
      if (otemp_set) begin
        over_temperature_error <= 1'b1;
      end else if (wr_status && pwdata[msc_pkg::ST_OTEMP]) begin
        over_temperature_error <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Line filter for comment lines
  logic [1:0] pos_q;
  logic [7:0] c0_q, c1_q;
  logic       skip_q;
  logic [7:0] up;
  logic       eol;
  logic       hit;
  assign up  = (cmd_char >= 8'h61 && cmd_char <= 8'h7A) ? cmd_char - 8'h20 : cmd_char;
  assign eol = cmd_char == msc_pkg::CH_CR || cmd_char == msc_pkg::CH_LF;
  always_comb begin
    unique case (pos_q)
      2'd0: hit = up == msc_pkg::CH_SEMI;
      2'd1: hit = c0_q == msc_pkg::CH_DASH && up == msc_pkg::CH_GT;
      2'd2: hit = (c0_q == msc_pkg::CH_S && c1_q == msc_pkg::CH_SL && up == msc_pkg::CH_N) ||
                  (c0_q == msc_pkg::CH_R && c1_q == msc_pkg::CH_E && up == msc_pkg::CH_M);
      default: hit = 1'b0;
    endcase
  end
  // Keyword is matched in the first three characters only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q      <= 2'd0;
      c0_q       <= 8'h00;
      c1_q       <= 8'h00;
      skip_q     <= 1'b0;
      line_valid <= 1'b0;
      line_char  <= 8'h00;
      line_drop  <= 1'b0;
    end else begin
      line_valid <= cmd_valid;
      if (cmd_valid) begin
        line_char <= cmd_char;
        line_drop <= (skip_q | hit) & ~eol;
        if (eol) begin
          pos_q  <= 2'd0;
          skip_q <= 1'b0;
        end else begin
          if (hit) begin
            skip_q <= 1'b1;
          end
          if (pos_q == 2'd0) begin
            c0_q <= up;
          end
          if (pos_q == 2'd1) begin
            c1_q <= up;
          end
          if (pos_q != 2'd3) begin
            pos_q <= pos_q + 2'd1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Input port query
  logic port_two_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_two_q <= 1'b0;
    end else if (cmd_valid) begin
      port_two_q <= cmd_from_port_two;
    end
  end
  logic [1:0] input_port_query;
  assign input_port_query = port_two_q ? msc_pkg::PORT_TWO_ID : msc_pkg::PORT_ONE_ID;

  // ==========================================================
  // Test display
  logic         test_q, tcont_q;
  logic [7:0]   ref_cnt_q;
  logic [15:0]  to_cnt_q;
  logic         esc_in;
  logic         ref_due;
  msc_pkg::msc_meas_t snap_q;
  assign esc_in  = (cmd_valid && cmd_char == msc_pkg::CH_ESC) ||
                   (wr_cmd && pwdata[msc_pkg::CMD_ESC]);
  assign ref_due = ms_tick && ref_cnt_q == 8'(msc_pkg::REFRESH_MS - 1);
  assign data_output_block = test_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_q       <= 1'b0;
      tcont_q      <= 1'b0;
      ref_cnt_q    <= 8'h0;
      to_cnt_q     <= 16'h0;
      test_refresh <= 1'b0;
      snap_q       <= '0;
    end else begin
      test_refresh <= test_q & ref_due;
      if (wr_cmd && pwdata[msc_pkg::CMD_TEST]) begin
        test_q    <= 1'b1;
        tcont_q   <= pwdata[msc_pkg::CMD_TCONT];
        ref_cnt_q <= 8'h0;
        to_cnt_q  <= 16'h0;
      end else if (test_q) begin
        if (esc_in) begin
          test_q <= 1'b0;
        end else if (ms_tick && !tcont_q &&
                     to_cnt_q == 16'(msc_pkg::TEST_TIMEOUT_MS - 1)) begin
          test_q <= 1'b0;
        end
        if (ms_tick) begin
          ref_cnt_q <= ref_due ? 8'h0 : ref_cnt_q + 8'h1;
          to_cnt_q  <= to_cnt_q + 16'h1;
        end
        if (ref_due) begin
          snap_q <= '{velocity_out, rate_in,
                      {digital_input_two, digital_input_one, digital_input_zero},
                      lighting};
        end
      end
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      msc_pkg::ADDR_HOLD:    rd_mux[15:0] = hold_q;
      msc_pkg::ADDR_MINRATE: rd_mux[6:0]  = minrate_q;
      msc_pkg::ADDR_COUNT:   rd_mux[15:0] = count_q;
      msc_pkg::ADDR_CONFIG:  rd_mux[2:0]  = cfg_q;
      msc_pkg::ADDR_STATUS: begin
        rd_mux[msc_pkg::ST_CRIT]  = critical_error;
        rd_mux[msc_pkg::ST_CALAB] = calab_q;
        rd_mux[msc_pkg::ST_OTEMP] = over_temperature_error;
        rd_mux[msc_pkg::ST_HOLDX] = expired_q;
        rd_mux[msc_pkg::ST_RLOW]  = rate_low_q;
        rd_mux[msc_pkg::ST_RED]   = red_led;
        rd_mux[msc_pkg::ST_STOUT] = status_output;
        rd_mux[msc_pkg::ST_LRUN]  = length_run;
        rd_mux[msc_pkg::ST_TEST]  = test_q;
        rd_mux[msc_pkg::ST_PORT+1:msc_pkg::ST_PORT] = input_port_query;
      end
      msc_pkg::ADDR_SNAPV:  rd_mux[22:0] = {snap_q.rate, snap_q.velocity};
      msc_pkg::ADDR_SNAPIO: rd_mux[15:0] = {snap_q.lighting, 5'h00, snap_q.din};
      default:              rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule

/* verification/msc_supervisor_properties.sv */
`timescale 1ns/1ns
module msc_checker #(
  parameter int TICK_CYC = 20000
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Measurement
  input wire logic        signal_valid,
  input wire logic [15:0] velocity_in,
  input wire logic [15:0] velocity_out,
  input wire logic        standstill,
  input wire logic        no_material,
  input wire logic        status_output,
  input wire logic        red_led,
  input wire logic [7:0]  temp_c,
  input wire logic        over_temperature_error,
  input wire logic        length_clear,
  input wire logic        length_run,
  // Command stream
  input wire logic        cmd_valid,
  input wire logic        line_valid
);
  // ==========================================================
  // Properties, all in the APB clock domain
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Zero wait states; a stall here would hang every host access
  AST_PREADY: assert property (psel |-> pready) else $error("pready low");
  AST_UNMAPPED: assert property (psel && penable && (paddr > 8'h1C || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  // Velocity path on signal present and lost
  AST_VEL_FOLLOW: assert property (signal_valid |=> velocity_out == $past(velocity_in))
    else $error("velocity not followed");
  AST_VEL_HOLD: assert property (!signal_valid ##1 !signal_valid |->
    velocity_out == $past(velocity_out) || velocity_out == 16'h0000) else $error("velocity not held");
  // Status output and red indicator, line pass, start pulse and over temperature
  AST_STILL_OPEN: assert property (standstill || no_material |-> status_output && red_led)
    else $error("standstill not flagged");
  AST_RED_STATUS: assert property (status_output |-> red_led)
    else $error("red off with status open");
  AST_LINE_PASS: assert property (cmd_valid |=> line_valid)
    else $error("char not forwarded");
  AST_START: assert property (psel && penable && pwrite && paddr == msc_pkg::ADDR_CMD
    && pwdata[msc_pkg::CMD_START] |=> length_clear && length_run) else $error("start not taken");
  AST_CLEAR_PULSE: assert property (length_clear |=> !length_clear)
    else $error("clear not a pulse");
  AST_OTEMP: assert property ($signed(temp_c) > 8'sd75 |=> over_temperature_error)
    else $error("over temperature missed");

  // Main scenarios
  COV_START: cover property (length_clear);
  COV_OTEMP: cover property ($rose(over_temperature_error));
  COV_LOSS: cover property (!signal_valid && red_led && !status_output);
endmodule

bind msc_supervisor msc_checker #(.TICK_CYC(TICK_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .signal_valid(signal_valid), .velocity_in(velocity_in), .velocity_out(velocity_out),
  .standstill(standstill), .no_material(no_material), .status_output(status_output),
  .red_led(red_led), .temp_c(temp_c), .over_temperature_error(over_temperature_error),
  .length_clear(length_clear), .length_run(length_run), .cmd_valid(cmd_valid),
  .line_valid(line_valid)
);

/* verification/msc_host_model.sv */
`timescale 1ns/1ns
module msc_host_model (
  // Clock
  input wire logic pclk,
  // Character stream towards the block
  output logic       cmd_valid,
  output logic [7:0] cmd_char,
  output logic       cmd_from_port_two
);
  // ==========================================================
  // Idle stream
  initial begin
    cmd_valid = 1'b0;
    cmd_char = 8'h00;
    cmd_from_port_two = 1'b0;
  end

  // One char per pulse; idle data is inverted so nothing stale looks valid
  task automatic send_char(input logic two, input logic [7:0] ch);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_char <= ch;
    cmd_from_port_two <= two;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_char <= ~ch;
  endtask

  // Text without line end
  task automatic send_str(input logic two, input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(two, s[i]);
    end
  endtask

  // Host ends a test display early
  task automatic send_esc(input logic two);
    send_char(two, msc_pkg::CH_ESC);
  endtask
endmodule

/* verification/test_measurement_supervisor_commands.sv */
`timescale 1ns/1ns
module test_measurement_supervisor_commands;
  // ==========================================================
  // Signals; one ms is TC cycles to keep the run short
  localparam int TC = 4;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        signal_valid = 1'b1, avg_end = 1'b0, standstill = 1'b0, no_material = 1'b0;
  logic        trigger_event = 1'b0, calibrating = 1'b0, err, cal_seen = 1'b0;
  logic [7:0]  paddr = 8'h00, temp_c = 8'h19, lighting = 8'hA5, drops = 8'h00, cmd_char, line_char;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] velocity_in = 16'h1234, velocity_out;
  logic [6:0]  rate_in = 7'h50;
  logic [2:0]  din = 3'h5;
  logic        pready, pslverr, cmd_valid, cmd_from_port_two, line_valid, line_drop, red_led;
  logic        status_output, length_run, length_clear, critical_error, cal_abort;
  logic        over_temperature_error, test_refresh, data_output_block;
  int          fail_count = 0, total_checks = 0, n;

  always #25 pclk = ~pclk;

  msc_supervisor #(.TICK_CYC(TC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .signal_valid(signal_valid), .velocity_in(velocity_in), .rate_in(rate_in), .avg_end(avg_end),
    .standstill(standstill), .no_material(no_material), .trigger_event(trigger_event),
    .calibrating(calibrating), .temp_c(temp_c), .digital_input_zero(din[0]),
    .digital_input_one(din[1]), .digital_input_two(din[2]), .lighting(lighting),
    .cmd_valid(cmd_valid), .cmd_char(cmd_char), .cmd_from_port_two(cmd_from_port_two),
    .line_valid(line_valid), .line_char(line_char), .line_drop(line_drop),
    .velocity_out(velocity_out), .red_led(red_led), .status_output(status_output),
    .length_run(length_run), .length_clear(length_clear), .critical_error(critical_error),
    .cal_abort(cal_abort), .over_temperature_error(over_temperature_error),
    .test_refresh(test_refresh), .data_output_block(data_output_block)
  );

  msc_host_model hm_u (
    .pclk(pclk), .cmd_valid(cmd_valid), .cmd_char(cmd_char), .cmd_from_port_two(cmd_from_port_two)
  );

  // Drop marks per char, and the one-cycle abort pulse
  always @(posedge pclk) begin
    if (line_valid) drops <= {drops[6:0], line_drop};
    if (cal_abort) cal_seen <= 1'b1;
  end

  // ==========================================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic avg();
    avg_end <= 1'b1;
    cyc(1);
    avg_end <= 1'b0;
    cyc(2);
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    cyc(30000);
    fail_count++;
    end_sim;
  end

  // ==========================================================
  // Tests
  initial begin
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    rdc(msc_pkg::ADDR_HOLD, 32'h64);
    rdc(msc_pkg::ADDR_COUNT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    cmp(32'(err), 32'h1);
    cmp(rd, 32'h0);
    // Hold range limits both sides
    wr(msc_pkg::ADDR_HOLD, 32'h9);
    rdc(msc_pkg::ADDR_HOLD, 32'h64);
    wr(msc_pkg::ADDR_HOLD, 32'h10000);
    rdc(msc_pkg::ADDR_HOLD, 32'h64);
    wr(msc_pkg::ADDR_HOLD, 32'hFFFF);
    rdc(msc_pkg::ADDR_HOLD, 32'hFFFF);
    wr(msc_pkg::ADDR_HOLD, 32'hA);
    rdc(msc_pkg::ADDR_HOLD, 32'hA);
    // Loss of 8 ms held, 12 ms zeroed; a second loss gets the full period
    signal_valid <= 1'b0;
    cyc(8 * TC);
    cmp(32'(velocity_out), 32'h1234);
    cmp(32'(red_led), 32'h0);
    cyc(4 * TC);
    cmp(32'(velocity_out), 32'h0);
    cmp(32'(red_led), 32'h1);
    signal_valid <= 1'b1;
    cyc(3);
    signal_valid <= 1'b0;
    cyc(8 * TC);
    cmp(32'(velocity_out), 32'h1234);
    signal_valid <= 1'b1;
    // Rate monitor: threshold range, evaluation instant, edge control
    wr(msc_pkg::ADDR_MINRATE, 32'h64);
    rdc(msc_pkg::ADDR_MINRATE, 32'h0);
    wr(msc_pkg::ADDR_MINRATE, 32'h63);
    rdc(msc_pkg::ADDR_MINRATE, 32'h63);
    rate_in <= 7'h62;
    cyc(3);
    cmp(32'(status_output), 32'h0);
    avg();
    cmp(32'({status_output, red_led}), 32'h3);
    wr(msc_pkg::ADDR_CONFIG, 32'h2);
    avg();
    cmp(32'(status_output), 32'h0);
    wr(msc_pkg::ADDR_CONFIG, 32'h0);
    rate_in <= 7'h63;
    avg();
    cmp(32'(status_output), 32'h0);
    rate_in <= 7'h01;
    wr(msc_pkg::ADDR_MINRATE, 32'h0);
    avg();
    cmp(32'(status_output), 32'h0);
    standstill <= 1'b1;
    cyc(2);
    cmp(32'({status_output, red_led}), 32'h3);
    standstill <= 1'b0;
    no_material <= 1'b1;
    cyc(2);
    cmp(32'({status_output, red_led}), 32'h3);
    no_material <= 1'b0;
    // Counter load at the top of range, then two separate triggers
    wr(msc_pkg::ADDR_COUNT, 32'hFFFD);
    repeat (2) begin
      trigger_event <= 1'b1;
      cyc(1);
      trigger_event <= 1'b0;
      cyc(1);
    end
    rdc(msc_pkg::ADDR_COUNT, 32'hFFFF);
    // Start and stop in both modes
    wr(msc_pkg::ADDR_CONFIG, 32'h4);
    wr(msc_pkg::ADDR_CMD, 32'h1);
    wr(msc_pkg::ADDR_CMD, 32'h2);
    cmp(32'(length_run), 32'h1);
    wr(msc_pkg::ADDR_CONFIG, 32'h1);
    wr(msc_pkg::ADDR_CMD, 32'h2);
    cmp(32'(length_run), 32'h0);
    wr(msc_pkg::ADDR_CMD, 32'h1);
    cmp(32'(length_run), 32'h1);
    // Loss while measuring and calibrating, error handling on
    calibrating <= 1'b1;
    signal_valid <= 1'b0;
    cyc(12 * TC);
    cmp(32'(critical_error), 32'h1);
    cmp(32'(cal_seen), 32'h1);
    signal_valid <= 1'b1;
    calibrating <= 1'b0;
    // Temperature at and just above the limit
    temp_c <= 8'h4B;
    cyc(3);
    cmp(32'(over_temperature_error), 32'h0);
    temp_c <= 8'h4C;
    cyc(3);
    cmp(32'(over_temperature_error), 32'h1);
    // Continuous test display: refresh spacing, snapshot, host escape
    wr(msc_pkg::ADDR_CMD, 32'hC);
    cmp(32'(data_output_block), 32'h1);
    n = 0;
    while (test_refresh !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    n = 0;
    cyc(1);
    while (test_refresh !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    cmp(32'(n + 1), 32'(250 * TC));
    rdc(msc_pkg::ADDR_SNAPIO, 32'hA505);
    hm_u.send_esc(1'b0);
    cyc(3);
    cmp(32'(data_output_block), 32'h0);
    wr(msc_pkg::ADDR_CMD, 32'h4);
    wr(msc_pkg::ADDR_CMD, 32'h10);
    cmp(32'(data_output_block), 32'h0);
    // Comment lines and the port that last spoke
    hm_u.send_char(1'b1, msc_pkg::CH_CR);
    hm_u.send_str(1'b1, ";A");
    hm_u.send_char(1'b1, msc_pkg::CH_CR);
    cyc(3);
    cmp(32'(drops[2:0]), 32'h6);
    apb(1'b0, msc_pkg::ADDR_STATUS, 32'h0);
    cmp(32'(rd[10:9]), 32'h2);
    hm_u.send_char(1'b0, msc_pkg::CH_R);
    hm_u.send_char(1'b0, msc_pkg::CH_E);
    hm_u.send_char(1'b0, msc_pkg::CH_M);
    hm_u.send_str(1'b0, "x");
    hm_u.send_char(1'b0, msc_pkg::CH_CR);
    cyc(3);
    cmp(32'(drops[4:0]), 32'h6);
    cmp(32'(line_char), 32'(msc_pkg::CH_CR));
    apb(1'b0, msc_pkg::ADDR_STATUS, 32'h0);
    cmp(32'(rd[10:9]), 32'h1);
    end_sim;
  end
endmodule
